// [rtl/bmon_mem_cmd.sv]
// Memory and register command layer of a single-wire battery monitor
//
// Overview of operation
// - Copy command moves scratchpad page into memory page
// - Copy read slots: 0 while busy, 1 after
// - Recall loads memory page into matching scratchpad
// - Temperature command converts once, then idles
// - Temperature read slots: 0 while converting, then 1
// - Voltage command converts input chosen by select bit
// - Busy flag set; result lands in page 00h
// - Other commands still run during voltage conversion
// - Voltage read slots: 0 while measuring, then 1
// - Copy busy bit stays 1 until copy ends
// - Temperature conversion finishes within one second
// - Voltage conversion finishes within two milliseconds
// - Memory write completes within fifty milliseconds
// - Read returns eight page bytes then CRC
// - Write stores up to eight bytes from byte 0
// - First byte 0Fh on page 00h sets four bits
// - Measurement results kept in page 00h
// - Reserved bits and bytes past the CRC read ones
// - Link reset ends write or read at once
`timescale 1ns/1ns
module bmon_mem_cmd #(
   parameter int TEMP_CYCLES_P = bmon_pkg::TEMP_CYCLES,
   parameter int VOLT_CYCLES_P = bmon_pkg::VOLT_CYCLES,
   parameter int COPY_CYCLES_P = bmon_pkg::COPY_CYCLES,
   parameter int NV_LIMIT_CYCLES_P = bmon_pkg::NV_LIMIT_CYCLES
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   // From the bit layer: link reset, received bytes, read requests
   input wire logic link_reset_i,
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_byte_i,
   input wire logic tx_req_i,
   // To the bit layer: byte answers and busy-poll bit
   output logic tx_valid_o,
   output logic [7:0] tx_byte_o,
   output logic slot_bit_o,
   // Analog side
   input wire bmon_pkg::meas_t meas_i,
   output logic temp_start_o,
   output logic volt_start_o,
   output logic volt_sel_o,
   output logic [2:0] acc_enable_o,
   // Status flags
   output logic memory_copy_busy_o,
   output logic voltage_conversion_busy_o,
   output logic temp_busy_o
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   bmon_pkg::core_t q; // Registered state
   bmon_pkg::core_t d; // Next state
   localparam logic [26:0] TEMP_LOAD = 27'(TEMP_CYCLES_P); // Conversion length
   localparam logic [26:0] VOLT_LOAD = 27'(VOLT_CYCLES_P); // Conversion length
   localparam logic [26:0] COPY_LOAD = 27'(COPY_CYCLES_P); // Copy length
   localparam logic [26:0] NV_LIMIT = 27'(NV_LIMIT_CYCLES_P); // Longest write

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      logic [7:0] wbyte;
      logic [7:0] rbyte;
      wbyte = rx_byte_i;
      rbyte = bmon_pkg::BYTE_ONES;
      d = q;
      d.tx_valid = 1'b0;
      d.temp_start = 1'b0;
      d.volt_start = 1'b0;
      // Copy timer; the page moves when the write finishes
      if (q.copy_cnt != bmon_pkg::CNT_IDLE) begin
         d.copy_cnt = q.copy_cnt - 27'h1;
         if (q.copy_cnt == 27'h1) begin
            d.store[q.copy_page] = q.scratch[q.copy_page];
         end
      end
      // Temperature timer; result stored in page 0
      if (q.temp_cnt != bmon_pkg::CNT_IDLE) begin
         d.temp_cnt = q.temp_cnt - 27'h1;
         if (q.temp_cnt == 27'h1) begin
            d.store[0][bmon_pkg::TEMP_LSB] = meas_i.temp[7:0];
            d.store[0][bmon_pkg::TEMP_LSB + 3'h1] = meas_i.temp[15:8];
         end
      end
      // Voltage timer; voltage and current stored in page 0
      if (q.volt_cnt != bmon_pkg::CNT_IDLE) begin
         d.volt_cnt = q.volt_cnt - 27'h1;
         if (q.volt_cnt == 27'h1) begin
            d.store[0][bmon_pkg::VOLT_LSB] = meas_i.volt[7:0];
            d.store[0][bmon_pkg::VOLT_LSB + 3'h1] = meas_i.volt[15:8];
            d.store[0][bmon_pkg::CURR_LSB] = meas_i.curr[7:0];
            d.store[0][bmon_pkg::CURR_LSB + 3'h1] = meas_i.curr[15:8];
         end
      end
      // Byte protocol; a link reset aborts the byte command in flight, the timers run on
      if (link_reset_i) begin
         d.state = bmon_pkg::ST_CMD;
         d.idx = 4'h0;
         d.crc = 8'h00;
      end else begin
         case (q.state)
            // Command byte
            bmon_pkg::ST_CMD: begin
               if (rx_valid_i) begin
                  d.cmd = rx_byte_i;
                  d.state = bmon_pkg::ST_PAGE;
                  case (rx_byte_i)
                     bmon_pkg::CMD_CONV_T: begin
                        d.temp_cnt = TEMP_LOAD;
                        d.temp_start = 1'b1;
                        d.poll = bmon_pkg::POLL_TEMP;
                        d.state = bmon_pkg::ST_DONE;
                     end
                     bmon_pkg::CMD_CONV_V: begin
                        d.volt_cnt = VOLT_LOAD;
                        d.volt_start = 1'b1;
                        d.poll = bmon_pkg::POLL_VOLT;
                        d.state = bmon_pkg::ST_DONE;
                     end
                     bmon_pkg::CMD_WRITE, bmon_pkg::CMD_READ, bmon_pkg::CMD_COPY, bmon_pkg::CMD_RECALL: begin
                        d.state = bmon_pkg::ST_PAGE;
                     end
                     // Unknown command: wait for a link reset
                     default: begin
                        d.state = bmon_pkg::ST_DONE;
                     end
                  endcase
               end
            end
            // Page number byte; only the low three bits select a page
            bmon_pkg::ST_PAGE: begin
               if (rx_valid_i) begin
                  d.page = rx_byte_i[2:0];
                  d.idx = 4'h0;
                  d.crc = 8'h00;
                  d.state = bmon_pkg::ST_DONE;
                  if (q.cmd == bmon_pkg::CMD_WRITE) begin
                     d.state = bmon_pkg::ST_WRITE;
                  end else if (q.cmd == bmon_pkg::CMD_READ) begin
                     d.state = bmon_pkg::ST_READ;
                  end else if (q.cmd == bmon_pkg::CMD_COPY) begin
                     d.copy_page = rx_byte_i[2:0];
                     d.copy_cnt = COPY_LOAD;
                     d.poll = bmon_pkg::POLL_COPY;
                  end else begin
                     d.scratch[rx_byte_i[2:0]] = q.store[rx_byte_i[2:0]];
                  end
               end
            end
            // Data bytes into the scratchpad from byte 0
            bmon_pkg::ST_WRITE: begin
               if (rx_valid_i) begin
                  if (q.page == 3'h0 && q.idx == 4'h0) begin
                     wbyte = rx_byte_i & bmon_pkg::CFG_MASK;
                  end
                  d.scratch[q.page][q.idx[2:0]] = wbyte;
                  d.idx = q.idx + 4'h1;
                  if (q.idx == bmon_pkg::PAGE_BYTES - 4'h1) begin
                     d.state = bmon_pkg::ST_DONE;
                  end
               end
            end
            // Page bytes, then CRC, then all ones
            bmon_pkg::ST_READ: begin
               if (tx_req_i) begin
                  d.tx_valid = 1'b1;
                  if (q.idx < bmon_pkg::PAGE_BYTES) begin
                     rbyte = q.scratch[q.page][q.idx[2:0]];
                     if (q.page == 3'h0 && q.idx == 4'h0) begin
                        rbyte = bmon_pkg::RESERVED_ONES | {1'b0, q.volt_busy, q.copy_busy, q.temp_busy,
                                                           q.scratch[0][0][3:0]};
                     end
                     d.crc = bmon_pkg::crc8(q.crc, rbyte);
                     d.idx = q.idx + 4'h1;
                  end else if (q.idx == bmon_pkg::CRC_POS) begin
                     rbyte = q.crc;
                     d.idx = bmon_pkg::END_POS;
                  end
                  d.tx_byte = rbyte;
               end
            end
            // Command finished: bytes ignored until a link reset
            default: begin
               d.state = bmon_pkg::ST_DONE;
            end
         endcase
      end
      // Busy flags follow the timers
      d.copy_busy = d.copy_cnt != bmon_pkg::CNT_IDLE;
      d.temp_busy = d.temp_cnt != bmon_pkg::CNT_IDLE;
      d.volt_busy = d.volt_cnt != bmon_pkg::CNT_IDLE;
      // Read-slot answer for the last busy-type command
      case (d.poll)
         bmon_pkg::POLL_COPY: d.slot_bit = !d.copy_busy;
         bmon_pkg::POLL_TEMP: d.slot_bit = !d.temp_busy;
         bmon_pkg::POLL_VOLT: d.slot_bit = !d.volt_busy;
         default: d.slot_bit = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         q <= '0;
         q.state <= bmon_pkg::ST_CMD;
         q.poll <= bmon_pkg::POLL_NONE;
         q.slot_bit <= 1'b1;
         q.tx_byte <= bmon_pkg::BYTE_ONES;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from the state register
   assign tx_valid_o = q.tx_valid;
   assign tx_byte_o = q.tx_byte;
   assign slot_bit_o = q.slot_bit;
   assign temp_start_o = q.temp_start;
   assign volt_start_o = q.volt_start;
   assign volt_sel_o = q.scratch[0][0][bmon_pkg::CFG_VSEL];
   assign acc_enable_o = q.scratch[0][0][2:0];
   assign memory_copy_busy_o = q.copy_busy;
   assign voltage_conversion_busy_o = q.volt_busy;
   assign temp_busy_o = q.temp_busy;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   bmon_pkg::page_t copy_src; // Page about to be copied
   bmon_pkg::page_t recall_src; // Memory page named by the incoming byte
   logic [7:0] crc_now; // Running CRC
   logic [15:0] volt_now; // Stored voltage word
   logic volt_cmd_now; // Voltage command taken at this edge
   logic temp_cmd_now; // Temperature command taken at this edge
   assign copy_src = q.scratch[q.copy_page];
   assign recall_src = q.store[rx_byte_i[2:0]];
   assign crc_now = q.crc;
   assign volt_now = {q.store[0][bmon_pkg::VOLT_LSB + 3'h1], q.store[0][bmon_pkg::VOLT_LSB]};
   // Conversion commands accepted in the command state; these restart a running timer
   assign volt_cmd_now = q.state == bmon_pkg::ST_CMD && rx_valid_i && !link_reset_i
                         && rx_byte_i == bmon_pkg::CMD_CONV_V;
   assign temp_cmd_now = q.state == bmon_pkg::ST_CMD && rx_valid_i && !link_reset_i
                         && rx_byte_i == bmon_pkg::CMD_CONV_T;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);

   sequence s_copy_end;
      q.copy_cnt == 27'h1 && q.copy_page != 3'h0
      && !(q.state == bmon_pkg::ST_PAGE && q.cmd == bmon_pkg::CMD_COPY && rx_valid_i && !link_reset_i);
   endsequence
   sequence s_recall_page;
      q.state == bmon_pkg::ST_PAGE && q.cmd == bmon_pkg::CMD_RECALL && rx_valid_i && !link_reset_i;
   endsequence
   sequence s_crc_req;
      q.state == bmon_pkg::ST_READ && tx_req_i && q.idx == bmon_pkg::CRC_POS && !link_reset_i;
   endsequence

   a_copy_moves: assert property (s_copy_end |=> q.store[q.copy_page] == $past(copy_src))
      else $error("copy did not move the page");
   a_copy_poll: assert property (q.poll == bmon_pkg::POLL_COPY && q.copy_busy
                                 ##1 q.copy_busy && !rx_valid_i |-> !slot_bit_o)
      else $error("copy poll bit high while busy");
   a_recall_load: assert property (s_recall_page |=> q.scratch[q.page] == $past(recall_src))
      else $error("recall did not load scratchpad");
   a_temp_poll: assert property (q.poll == bmon_pkg::POLL_TEMP |-> slot_bit_o == !q.temp_busy)
      else $error("temperature poll bit wrong");
   a_temp_bound: assert property (q.temp_cnt <= TEMP_LOAD)
      else $error("temperature conversion too long");
   a_volt_bound: assert property (q.volt_cnt <= VOLT_LOAD && q.volt_busy == (q.volt_cnt != 27'h0))
      else $error("voltage conversion too long");
   a_volt_result: assert property (q.volt_cnt == 27'h1 && !volt_cmd_now
                                   |=> !q.volt_busy && volt_now == $past(meas_i.volt))
      else $error("voltage result not stored");
   a_volt_start: assert property (volt_cmd_now |=> volt_start_o && voltage_conversion_busy_o
                                  && !slot_bit_o && q.volt_cnt == VOLT_LOAD)
      else $error("voltage conversion did not start");
   a_temp_start: assert property (temp_cmd_now |=> temp_start_o && temp_busy_o && !slot_bit_o)
      else $error("temperature conversion did not start");
   a_volt_poll: assert property (q.poll == bmon_pkg::POLL_VOLT |-> slot_bit_o == !q.volt_busy)
      else $error("voltage poll bit wrong");
   a_copy_limit: assert property (q.copy_cnt <= NV_LIMIT && q.copy_busy == (q.copy_cnt != 27'h0))
      else $error("copy exceeds write limit");
   a_crc_byte: assert property (s_crc_req |=> tx_valid_o && tx_byte_o == $past(crc_now))
      else $error("CRC byte wrong");
   a_beyond_ones: assert property (q.state == bmon_pkg::ST_READ && tx_req_i && q.idx == bmon_pkg::END_POS
                                   && !link_reset_i |=> tx_byte_o == 8'hff)
      else $error("byte past CRC not all ones");
   a_cfg_write: assert property (q.state == bmon_pkg::ST_WRITE && q.page == 3'h0 && q.idx == 4'h0
                                 && rx_valid_i && rx_byte_i == 8'h0f && !link_reset_i
                                 |=> acc_enable_o == 3'h7 && volt_sel_o)
      else $error("config bits not set");
   a_reset_abort: assert property (link_reset_i |=> q.state == bmon_pkg::ST_CMD)
      else $error("link reset did not abort");
   a_done_ignores: assert property (q.state == bmon_pkg::ST_DONE && !link_reset_i |=>
                                    q.state == bmon_pkg::ST_DONE && !tx_valid_o)
      else $error("bytes accepted after command end");
endmodule

// [rtl/bmon_pkg.sv]
// Constants and types for the battery monitor memory command layer
package bmon_pkg;
   // Command bytes
   localparam logic [7:0] CMD_WRITE = 8'h4e;
   localparam logic [7:0] CMD_READ = 8'hbe;
   localparam logic [7:0] CMD_COPY = 8'h48;
   localparam logic [7:0] CMD_RECALL = 8'hb8;
   localparam logic [7:0] CMD_CONV_T = 8'h44;
   localparam logic [7:0] CMD_CONV_V = 8'hb4;
   // Timing, times in milliseconds
   localparam int CLK_HZ = 125000000;
   localparam int TEMP_TIME_MS = 1000;
   localparam int VOLT_TIME_MS = 2;
   localparam int COPY_TIME_MS = 10;
   localparam int NV_LIMIT_MS = 50;
   localparam int TEMP_CYCLES = TEMP_TIME_MS * (CLK_HZ / 1000);
   localparam int VOLT_CYCLES = VOLT_TIME_MS * (CLK_HZ / 1000);
   localparam int COPY_CYCLES = COPY_TIME_MS * (CLK_HZ / 1000);
   localparam int NV_LIMIT_CYCLES = NV_LIMIT_MS * (CLK_HZ / 1000);
   // Byte positions inside a page
   localparam logic [3:0] PAGE_BYTES = 4'h8;
   localparam logic [3:0] CRC_POS = 4'h8;
   localparam logic [3:0] END_POS = 4'h9;
   localparam logic [2:0] TEMP_LSB = 3'h1;
   localparam logic [2:0] VOLT_LSB = 3'h3;
   localparam logic [2:0] CURR_LSB = 3'h5;
   // Status/configuration byte 0 of page 0
   localparam int CFG_VSEL = 3;
   localparam logic [7:0] CFG_MASK = 8'h0f;
   localparam logic [7:0] RESERVED_ONES = 8'h80;
   // Reset values
   localparam logic [26:0] CNT_IDLE = 27'h0;
   localparam logic [7:0] BYTE_ONES = 8'hff;
   typedef enum logic [2:0] {ST_CMD, ST_PAGE, ST_WRITE, ST_READ, ST_DONE} state_t;
   typedef enum logic [1:0] {POLL_NONE, POLL_COPY, POLL_TEMP, POLL_VOLT} poll_t;
   typedef logic [7:0][7:0] page_t;
   typedef logic [7:0][7:0][7:0] bank_t;
   // Measurement results from the analog side
   typedef struct packed {
      logic [15:0] temp;
      logic [15:0] volt;
      logic [15:0] curr;
   } meas_t;
   // Whole state of the command layer
   typedef struct packed {
      state_t state;
      logic [7:0] cmd;
      logic [2:0] page;
      logic [3:0] idx;
      logic [7:0] crc;
      poll_t poll;
      bank_t scratch;
      bank_t store;
      logic [2:0] copy_page;
      logic [26:0] copy_cnt;
      logic [26:0] temp_cnt;
      logic [26:0] volt_cnt;
      logic copy_busy;
      logic temp_busy;
      logic volt_busy;
      logic temp_start;
      logic volt_start;
      logic tx_valid;
      logic [7:0] tx_byte;
      logic slot_bit;
   } core_t;
   // Running CRC8, polynomial x^8+x^5+x^4+1, data least significant bit first
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      logic fb;
      r = c;
      for (int i = 0; i < 8; i++) begin
         fb = r[0] ^ d[i];
         r = r >> 1;
         if (fb) begin
            r = r ^ 8'h8c;
         end
      end
      return r;
   endfunction
endpackage

// [tb/bmon_master.sv]
// Behavioural single-wire master as seen at the byte side of the command layer
`timescale 1ns/1ns
module bmon_master (
   // Clock
   input wire logic clock_i,
   // Answers from the command layer
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_byte_i,
   // Requests toward the command layer
   output logic link_reset_o,
   output logic rx_valid_o,
   output logic [7:0] rx_byte_o,
   output logic tx_req_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // Idle levels from time zero
   initial begin
      link_reset_o = 1'b0;
      rx_valid_o = 1'b0;
      rx_byte_o = 8'h00;
      tx_req_o = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Link reset pulse that opens every command sequence
   task automatic link_reset();
      @(posedge clock_i);
      link_reset_o <= 1'b1;
      @(posedge clock_i);
      link_reset_o <= 1'b0;
   endtask
   // One byte to the device; released data shows the inverse, not a stale copy
   task automatic send(input logic [7:0] b);
      @(posedge clock_i);
      rx_valid_o <= 1'b1;
      rx_byte_o <= b;
      @(posedge clock_i);
      rx_valid_o <= 1'b0;
      rx_byte_o <= ~b;
   endtask
   // Reset, then command byte and page; page kept inside 00h to 07h
   task automatic command(input logic [7:0] c, input logic [2:0] p);
      link_reset();
      send(c);
      send({5'h00, p});
   endtask
   // One read request; the answer is awaited for a bounded number of cycles
   task automatic read(output logic [7:0] b, output logic got);
      got = 1'b0;
      b = 8'h00;
      @(posedge clock_i);
      tx_req_o <= 1'b1;
      @(posedge clock_i);
      tx_req_o <= 1'b0;
      for (int i = 0; i < 3 && !got; i++) begin
         #1;
         if (tx_valid_i === 1'b1) begin
            got = 1'b1;
            b = tx_byte_i;
         end else begin
            @(posedge clock_i);
         end
      end
   endtask
endmodule

// [tb/tb_battery_monitor_memory_commands.sv]
// Self-checking bench for the battery monitor memory command layer
`timescale 1ns/1ns
module tb_battery_monitor_memory_commands;
   // Shortened conversion and copy times
   localparam int TEMP_C = 40;
   localparam int VOLT_C = 20;
   localparam int COPY_C = 30;
   logic clock_i = 1'b0;
   logic reset_i = 1'b1;
   logic link_reset_i, rx_valid_i, tx_req_i, tx_valid_o, slot_bit_o;
   logic [7:0] rx_byte_i, tx_byte_o;
   logic temp_start_o, volt_start_o, volt_sel_o;
   logic [2:0] acc_enable_o;
   logic memory_copy_busy_o, voltage_conversion_busy_o, temp_busy_o;
   bmon_pkg::meas_t meas_i = '{temp: 16'h1234, volt: 16'h5678, curr: 16'h9abc};
   int n_errors = 0;
   int check_count = 0;
   int starts_t = 0;
   int starts_v = 0;
   logic [7:0] got [0:9];
   logic ok;
   always #4 clock_i = ~clock_i;
   ////////////////////////////////////////////////////////////////////////////////
   bmon_mem_cmd #(.TEMP_CYCLES_P(TEMP_C), .VOLT_CYCLES_P(VOLT_C), .COPY_CYCLES_P(COPY_C),
      .NV_LIMIT_CYCLES_P(100)) dut_u (.clock_i(clock_i), .reset_i(reset_i), .link_reset_i(link_reset_i),
      .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i), .tx_req_i(tx_req_i), .tx_valid_o(tx_valid_o),
      .tx_byte_o(tx_byte_o), .slot_bit_o(slot_bit_o), .meas_i(meas_i), .temp_start_o(temp_start_o),
      .volt_start_o(volt_start_o), .volt_sel_o(volt_sel_o), .acc_enable_o(acc_enable_o),
      .memory_copy_busy_o(memory_copy_busy_o), .voltage_conversion_busy_o(voltage_conversion_busy_o),
      .temp_busy_o(temp_busy_o));
   bmon_master mst_u (.clock_i(clock_i), .tx_valid_i(tx_valid_o), .tx_byte_i(tx_byte_o),
      .link_reset_o(link_reset_i), .rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i), .tx_req_o(tx_req_i));
   ////////////////////////////////////////////////////////////////////////////////
   // Counts conversion start pulses as they pass
   always @(posedge clock_i) begin
      if (temp_start_o === 1'b1) begin
         starts_t++;
      end
      if (volt_start_o === 1'b1) begin
         starts_v++;
      end
   end
   // Compare one byte and count it
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   // Fill pattern of a page byte
   function automatic logic [7:0] pv(input int i);
      return 8'h5a + 8'(i * 37);
   endfunction
   // Reflected CRC8 step with polynomial 8ch, bit 0 first
   function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ 8'h8c) : (r >> 1);
      end
      return r;
   endfunction
   // Busy flag by kind: 0 copy, 1 temperature, 2 voltage
   function automatic logic bsy(input int k);
      return k == 0 ? memory_copy_busy_o : (k == 1 ? temp_busy_o : voltage_conversion_busy_o);
   endfunction
   // Read n bytes of a scratchpad page into got
   task automatic rd_page(input logic [2:0] p, input int n);
      mst_u.command(bmon_pkg::CMD_READ, p);
      for (int i = 0; i < n; i++) begin
         mst_u.read(got[i], ok);
         check({7'h00, ok}, 8'h01, "read answer");
      end
   endtask
   // Write n pattern bytes, xored with m, to a scratchpad page
   task automatic wr_page(input logic [2:0] p, input int n, input logic [7:0] m);
      mst_u.command(bmon_pkg::CMD_WRITE, p);
      for (int i = 0; i < n; i++) begin
         mst_u.send(pv(i) ^ m);
      end
   endtask
   // Busy must rise within four cycles, hold for about len cycles, slot bit tracking it
   task automatic run_busy(input int k, input int len);
      int n;
      n = 0;
      #1;
      while (bsy(k) !== 1'b1 && n < 4) begin
         @(posedge clock_i);
         #1;
         n++;
      end
      check({7'h00, bsy(k)}, 8'h01, "busy rises");
      check({7'h00, slot_bit_o}, 8'h00, "slot while busy");
      n = 0;
      while (bsy(k) !== 1'b0 && n < len + 8) begin
         @(posedge clock_i);
         #1;
         n++;
      end
      check({7'h00, n >= len - 3 && n <= len + 3}, 8'h01, "busy length");
      check({7'h00, slot_bit_o}, 8'h01, "slot when done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Idle outputs after reset; a read request with no command is refused
   task automatic t_reset();
      check(tx_byte_o, 8'hff, "idle byte");
      check({4'h0, slot_bit_o, memory_copy_busy_o, voltage_conversion_busy_o, temp_busy_o}, 8'h08, "flags");
      check({4'h0, volt_sel_o, acc_enable_o}, 8'h00, "config");
      mst_u.read(got[0], ok);
      check({7'h00, ok}, 8'h00, "refused read");
   endtask
   // Config byte, nine-byte write with last ignored, full read with CRC and ones
   task automatic t_write_read();
      logic [7:0] c;
      mst_u.command(bmon_pkg::CMD_WRITE, 3'h0);
      mst_u.send(8'h0f);
      #1;
      check({4'h0, volt_sel_o, acc_enable_o}, 8'h0f, "four config bits");
      rd_page(3'h0, 1);
      check(got[0], 8'h8f, "status byte reserved bit");
      wr_page(3'h3, 9, 8'h00);
      rd_page(3'h3, 10);
      c = 8'h00;
      for (int i = 0; i < 8; i++) begin
         check(got[i], pv(i), "page byte");
         c = crc_step(c, pv(i));
      end
      check(got[8], c, "crc");
      check(got[9], 8'hff, "past end");
   endtask
   // Copy with busy polling, stale scratch read, then recall restores memory
   task automatic t_copy();
      int k;
      mst_u.command(bmon_pkg::CMD_COPY, 3'h3);
      run_busy(0, COPY_C);
      k = starts_t;
      mst_u.send(bmon_pkg::CMD_CONV_T);
      repeat (3) @(posedge clock_i);
      check(8'(starts_t - k), 8'h00, "byte after copy ignored");
      wr_page(3'h3, 8, 8'hff);
      rd_page(3'h3, 1);
      check(got[0], ~pv(0), "scratch not memory");
      mst_u.command(bmon_pkg::CMD_RECALL, 3'h3);
      rd_page(3'h3, 8);
      for (int i = 0; i < 8; i++) begin
         check(got[i], pv(i), "recalled byte");
      end
   endtask
   // One temperature conversion, one start pulse, busy for its time
   task automatic t_temp();
      int k;
      k = starts_t;
      mst_u.link_reset();
      mst_u.send(bmon_pkg::CMD_CONV_T);
      run_busy(1, TEMP_C);
      check(8'(starts_t - k), 8'h01, "one conversion");
   endtask
   // Voltage conversion timed, then one with a write under way, results in page 0
   task automatic t_volt();
      int n;
      int k;
      k = starts_v;
      mst_u.link_reset();
      mst_u.send(bmon_pkg::CMD_CONV_V);
      run_busy(2, VOLT_C);
      check(8'(starts_v - k), 8'h01, "one voltage start");
      mst_u.link_reset();
      mst_u.send(bmon_pkg::CMD_CONV_V);
      mst_u.command(bmon_pkg::CMD_WRITE, 3'h5);
      mst_u.send(8'h3c);
      #1;
      check({7'h00, voltage_conversion_busy_o}, 8'h01, "still converting");
      n = 0;
      while (voltage_conversion_busy_o !== 1'b0 && n < VOLT_C + 8) begin
         @(posedge clock_i);
         #1;
         n++;
      end
      rd_page(3'h5, 1);
      check(got[0], 8'h3c, "write during conversion");
      mst_u.command(bmon_pkg::CMD_RECALL, 3'h0);
      rd_page(3'h0, 7);
      check(got[1], meas_i.temp[7:0], "temp low");
      check(got[2], meas_i.temp[15:8], "temp high");
      check(got[3], meas_i.volt[7:0], "volt low");
      check(got[4], meas_i.volt[15:8], "volt high");
      check(got[5], meas_i.curr[7:0], "current low");
      check(got[6], meas_i.curr[15:8], "current high");
   endtask
   // Link reset cuts a read short; a new read starts again at byte 0
   task automatic t_abort();
      rd_page(3'h3, 2);
      check(got[1], pv(1), "second byte before cut");
      mst_u.link_reset();
      mst_u.read(got[2], ok);
      check({7'h00, ok}, 8'h00, "read ended by reset");
      rd_page(3'h3, 1);
      check(got[0], pv(0), "fresh read");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Counts, verdict and end of run
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      #200000;
      n_errors++;
      final_report();
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge clock_i);
      reset_i <= 1'b0;
      @(posedge clock_i);
      #1;
      t_reset();
      t_write_read();
      t_copy();
      t_temp();
      t_volt();
      t_abort();
      final_report();
   end
endmodule
